// ---- src/conv_start_pulse.sv ----
`timescale 1ns/1ps
module conv_start_pulse
  import ext_ctrl_pkg::*;
#(
  parameter int LEN = SOC_PULSE_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic fire,
  input  wire logic enable,
  output logic      pin_o,
  output logic      pin_oe_n
);
  localparam int CW = $clog2(LEN);
  localparam logic [CW-1:0] LAST = CW'(LEN - 1);

  typedef enum logic {IDLE, PULSE} soc_state_e;
  soc_state_e    state_q;
  logic [CW-1:0] cnt_q;
  logic          pin_q;

  // events landing inside a running pulse are merged into it
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= IDLE;
      cnt_q   <= '0;
      pin_q   <= 1'b1;
    end else if (ce) begin
      case (state_q)
        IDLE: begin
          cnt_q <= '0;
          if (fire && enable) begin
            state_q <= PULSE;
            pin_q   <= 1'b0;
          end
        end
        PULSE: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == LAST) begin
            state_q <= IDLE;
            pin_q   <= 1'b1;
          end
        end
        default: state_q <= IDLE;
      endcase
    end
  end

  assign pin_o    = pin_q;
  assign pin_oe_n = ~enable;

  logic [7:0] low_run_q;
  always_ff @(posedge clock) begin
    if (rst) low_run_q <= '0;
    else if (ce) low_run_q <= pin_q ? 8'h00 : low_run_q + 8'h01;
  end

  soc_width_a: assert property (@(posedge clock) disable iff (rst || !ce)
      $rose(pin_q) |-> low_run_q == 8'(LEN))
    else $error("conversion start pulse has wrong width");

endmodule : conv_start_pulse

// ---- src/ext_ctrl_pkg.sv ----
package ext_ctrl_pkg;

  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int REG_W  = 16;
  localparam int IDX_W  = ADDR_W - 2;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_EXT     = 16'h7409;
  localparam logic [IDX_W-1:0] IDX_MASK_BA = 16'h752c;
  localparam logic [IDX_W-1:0] IDX_MASK_BB = 16'h752d;
  localparam logic [IDX_W-1:0] IDX_MASK_BC = 16'h752e;
  localparam logic [IDX_W-1:0] IDX_GPT     = 16'h7600;
  localparam logic [IDX_W-1:0] IDX_COM     = 16'h7601;
  localparam logic [IDX_W-1:0] IDX_FLAG    = 16'h7602;
  localparam logic [IDX_W-1:0] IDX_MASK_A  = 16'h7603;
  localparam logic [IDX_W-1:0] IDX_T1CTL   = 16'h7604;
  localparam logic [IDX_W-1:0] IDX_T2CTL   = 16'h7605;

  // extension control fields
  localparam int EXT_INDEP = 0;
  localparam int EXT_QUAL  = 1;
  localparam int EXT_INDEX = 2;
  localparam int EXT_SOC   = 3;
  // timer group control fields
  localparam int GPT_T2TRIPE = 12;
  localparam int GPT_T1TRIPE = 11;
  localparam int GPT_TOE     = 6;
  localparam int GPT_T1OE    = 4;
  // compare control, flag, mask and clock select fields
  localparam int COM_FOE      = 9;
  localparam int COM_FOE_LO   = 5;
  localparam int COM_TRIPE_LO = 0;
  localparam int FLAG_PROT    = 0;
  localparam int MASK_PROT    = 0;
  localparam int CLK_SEL_LO   = 4;

  localparam logic [REG_W-1:0] EXT_RST     = 16'h0000;
  localparam logic [REG_W-1:0] GPT_RST     = 16'h1800;
  localparam logic [REG_W-1:0] COM_RST     = 16'h0000;
  localparam logic [REG_W-1:0] MASK_A_RST  = 16'h0001;
  localparam logic [REG_W-1:0] MASK_BA_RST = 16'h0001;
  localparam logic [REG_W-1:0] MASK_BB_RST = 16'h0000;
  localparam logic [REG_W-1:0] MASK_BC_RST = 16'h0000;
  localparam logic [REG_W-1:0] TCTL_RST    = 16'h0000;

  localparam logic [REG_W-1:0] EXT_WMASK     = 16'h000f;
  localparam logic [REG_W-1:0] GPT_WMASK     = 16'h1870;
  localparam logic [REG_W-1:0] COM_WMASK     = 16'h02e7;
  localparam logic [REG_W-1:0] MASK_A_WMASK  = 16'h0001;
  localparam logic [REG_W-1:0] MASK_BA_WMASK = 16'h078f;
  localparam logic [REG_W-1:0] MASK_BB_WMASK = 16'h000f;
  localparam logic [REG_W-1:0] MASK_BC_WMASK = 16'h0007;
  localparam logic [REG_W-1:0] TCTL_WMASK    = 16'h0030;

  localparam logic [1:0] CLKS_INT = 2'h0;
  localparam logic [1:0] CLKS_EXT = 2'h1;
  localparam logic [1:0] CLKS_QEP = 2'h3;

  localparam int SOC_PULSE_CYCLES = 32;
  localparam int QUAL_CYCLES      = 6;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    REG_NONE, REG_EXT, REG_GPT, REG_COM, REG_FLAG, REG_MASK_A,
    REG_MASK_BA, REG_MASK_BB, REG_MASK_BC, REG_T1CTL, REG_T2CTL
  } reg_sel_e;

  typedef struct packed {
    logic [1:0] tmr;
    logic [5:0] fc;
  } cmp_pins_s;

  typedef struct packed {
    logic       idx;
    logic       qb;
    logic       qa;
    logic [2:0] fc_trip;
    logic       t2_trip;
    logic       t1_trip;
  } sense_pins_s;

  localparam int SENSE_W = $bits(sense_pins_s);

  function automatic reg_sel_e decode_reg(input logic [ADDR_W-1:0] a);
    logic [IDX_W-1:0] idx;
    idx = a[ADDR_W-1:2];
    if (idx == IDX_EXT) return REG_EXT;
    else if (idx == IDX_GPT) return REG_GPT;
    else if (idx == IDX_COM) return REG_COM;
    else if (idx == IDX_FLAG) return REG_FLAG;
    else if (idx == IDX_MASK_A) return REG_MASK_A;
    else if (idx == IDX_MASK_BA) return REG_MASK_BA;
    else if (idx == IDX_MASK_BB) return REG_MASK_BB;
    else if (idx == IDX_MASK_BC) return REG_MASK_BC;
    else if (idx == IDX_T1CTL) return REG_T1CTL;
    else if (idx == IDX_T2CTL) return REG_T2CTL;
    else return REG_NONE;
  endfunction : decode_reg

endpackage : ext_ctrl_pkg

// ---- src/input_conditioner.sv ----
`timescale 1ns/1ps
module input_conditioner
  import ext_ctrl_pkg::*;
#(
  parameter int              W        = SENSE_W,
  parameter int              QUAL_LEN = QUAL_CYCLES,
  parameter logic [W-1:0]    RST_VAL  = '1
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] clean
);
  localparam int CW = $clog2(QUAL_LEN + 1);
  localparam logic [CW-1:0] LAST = CW'(QUAL_LEN - 1);

  for (genvar i = 0; i < W; i++) begin : g_bit
    logic          s1_q, s2_q, clean_q;
    logic [CW-1:0] cnt_q;
    wire           differs = s2_q != clean_q;
    // a level must hold for the whole window; shorter glitches never pass
    always_ff @(posedge clock) begin
      if (rst) begin
        s1_q    <= RST_VAL[i];
        s2_q    <= RST_VAL[i];
        clean_q <= RST_VAL[i];
        cnt_q   <= '0;
      end else if (ce) begin
        s1_q    <= raw[i];
        s2_q    <= s1_q;
        cnt_q   <= (differs && cnt_q != LAST) ? cnt_q + 1'b1 : '0;
        clean_q <= (differs && cnt_q == LAST) ? s2_q : clean_q;
      end
    end
    assign clean[i] = clean_q;
  end

endmodule : input_conditioner

// ---- src/trip_hiz_ext_ctrl.sv ----
`timescale 1ns/1ps
module trip_hiz_ext_ctrl
  import ext_ctrl_pkg::*;
#(
  parameter int QUAL_LEN = QUAL_CYCLES,
  parameter int SOC_LEN  = SOC_PULSE_CYCLES
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [DATA_W-1:0]      rdata,
  output logic [1:0]             rresp,
  input  wire sense_pins_s       sense_raw,
  input  wire cmp_pins_s         cmp_drive,
  output cmp_pins_s              cmp_pin_o,
  output cmp_pins_s              cmp_pin_oe_n,
  input  wire logic              conv_event,
  output logic                   internal_conv_trigger,
  output logic                   conv_start_pin_o,
  output logic                   conv_start_pin_oe_n,
  output logic                   quad_timer_clear,
  output logic [2:0]             timer1_clk_sel,
  output logic [2:0]             timer2_clk_sel,
  output logic                   protection_irq,
  output logic [REG_W-1:0]       b_group_a_irq_en,
  output logic [3:0]             b_timer4_irq_en,
  output logic [2:0]             b_capture_irq_en
);

  // one-hot {quadrature, external, internal}; reserved code selects nothing
  function automatic logic [2:0] clk_src_onehot(input logic [1:0] code);
    if (code == CLKS_INT) return 3'h1;
    else if (code == CLKS_EXT) return 3'h2;
    else if (code == CLKS_QEP) return 3'h4;
    else return 3'h0;
  endfunction : clk_src_onehot

  function automatic logic [REG_W-1:0] wmerge(input logic [REG_W-1:0] old,
                                              input logic [REG_W-1:0] val,
                                              input logic [1:0]       strb,
                                              input logic [REG_W-1:0] wmask);
    logic [REG_W-1:0] lanes;
    lanes = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
    return (old & ~lanes) | (val & lanes);
  endfunction : wmerge

  // ---------------- input conditioning
  sense_pins_s pins;

  input_conditioner #(
    .W        (SENSE_W),
    .QUAL_LEN (QUAL_LEN),
    .RST_VAL  ({1'b0, 1'b0, 1'b0, 3'h7, 1'b1, 1'b1})
  ) u_cond (
    .clock (clock),
    .rst   (rst),
    .ce    (ce),
    .raw   (sense_raw),
    .clean (pins)
  );

  // ---------------- register bus
  logic              aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [REG_W-1:0]  w_data_q;
  logic [1:0]        w_strb_q, bresp_q, rresp_q;
  logic [REG_W-1:0]  rdata_q;
  logic [REG_W-1:0]  rd_word;

  wire aw_take = awvalid && awready;
  wire w_take  = wvalid && wready;
  wire wr_fire = ce && aw_hold_q && w_hold_q && !bvalid_q;
  wire ar_take = arvalid && arready;

  assign awready = ce && !aw_hold_q && !bvalid_q;
  assign wready  = ce && !w_hold_q && !bvalid_q;
  assign arready = ce && !rvalid_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign rvalid  = rvalid_q;
  assign rresp   = rresp_q;
  assign rdata   = {{(DATA_W-REG_W){1'b0}}, rdata_q};

  reg_sel_e wr_sel, rd_sel;
  assign wr_sel = decode_reg(aw_addr_q);
  assign rd_sel = decode_reg(araddr);

  wire wr_ext    = wr_fire && wr_sel == REG_EXT;
  wire wr_gpt    = wr_fire && wr_sel == REG_GPT;
  wire wr_com    = wr_fire && wr_sel == REG_COM;
  wire wr_flag   = wr_fire && wr_sel == REG_FLAG;
  wire wr_mask_a = wr_fire && wr_sel == REG_MASK_A;
  wire wr_ba     = wr_fire && wr_sel == REG_MASK_BA;
  wire wr_bb     = wr_fire && wr_sel == REG_MASK_BB;
  wire wr_bc     = wr_fire && wr_sel == REG_MASK_BC;
  wire wr_t1     = wr_fire && wr_sel == REG_T1CTL;
  wire wr_t2     = wr_fire && wr_sel == REG_T2CTL;

  always_ff @(posedge clock) begin
    if (rst) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      rvalid_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      bresp_q   <= RESP_OKAY;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= '0;
    end else if (ce) begin
      if (aw_take) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (w_take) begin
        w_hold_q <= 1'b1;
        w_data_q <= wdata[REG_W-1:0];
        w_strb_q <= wstrb[1:0];
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= (wr_sel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (bready) begin
        bvalid_q <= 1'b0;
      end
      if (ar_take) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_word;
        rresp_q  <= (rd_sel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ---------------- control registers
  logic [REG_W-1:0] ext_q, gpt_q, com_q, mask_a_q, ba_q, bb_q, bc_q, t1_q, t2_q;
  logic             flag_q;

  wire indep = ext_q[EXT_INDEP];

  // trip hits: only in independent mode and only when enabled
  wire       t1_hit = indep && gpt_q[GPT_T1TRIPE] && !pins.t1_trip;
  wire       t2_hit = indep && gpt_q[GPT_T2TRIPE] && !pins.t2_trip;
  logic [2:0] fc_hit;
  for (genvar i = 0; i < 3; i++) begin : g_fc_hit
    assign fc_hit[i] = indep && com_q[COM_TRIPE_LO+i] && !pins.fc_trip[i];
  end

  // legacy protection path; the pin doubles as timer 1 trip
  wire prot_active = !indep && mask_a_q[MASK_PROT] && !pins.t1_trip;

  wire flag_set = indep ? (t1_hit || t2_hit || |fc_hit) : !pins.t1_trip;
  wire flag_clr = wr_flag && w_strb_q[0] && w_data_q[FLAG_PROT];

  // hardware clears beat a simultaneous software set; no automatic restore
  wire [REG_W-1:0] gpt_hw_clr = indep ? (REG_W'({t2_hit, t1_hit}) << GPT_T1OE)
                                      : (REG_W'(prot_active) << GPT_TOE);
  wire [REG_W-1:0] com_hw_clr = indep ? (REG_W'(fc_hit) << COM_FOE_LO)
                                      : (REG_W'(prot_active) << COM_FOE);

  wire [REG_W-1:0] ext_d = wr_ext ? wmerge(ext_q, w_data_q, w_strb_q, EXT_WMASK) : ext_q;
  wire [REG_W-1:0] gpt_w = wr_gpt ? wmerge(gpt_q, w_data_q, w_strb_q, GPT_WMASK) : gpt_q;
  wire [REG_W-1:0] com_w = wr_com ? wmerge(com_q, w_data_q, w_strb_q, COM_WMASK) : com_q;
  wire [REG_W-1:0] gpt_d = gpt_w & ~gpt_hw_clr;
  wire [REG_W-1:0] com_d = com_w & ~com_hw_clr;
  wire             flag_d = (flag_q && !flag_clr) || flag_set;
  wire [REG_W-1:0] mask_a_d = wr_mask_a ? wmerge(mask_a_q, w_data_q, w_strb_q, MASK_A_WMASK)
                                        : mask_a_q;
  wire [REG_W-1:0] ba_d = wr_ba ? wmerge(ba_q, w_data_q, w_strb_q, MASK_BA_WMASK) : ba_q;
  wire [REG_W-1:0] bb_d = wr_bb ? wmerge(bb_q, w_data_q, w_strb_q, MASK_BB_WMASK) : bb_q;
  wire [REG_W-1:0] bc_d = wr_bc ? wmerge(bc_q, w_data_q, w_strb_q, MASK_BC_WMASK) : bc_q;
  wire [REG_W-1:0] t1_d = wr_t1 ? wmerge(t1_q, w_data_q, w_strb_q, TCTL_WMASK) : t1_q;
  wire [REG_W-1:0] t2_d = wr_t2 ? wmerge(t2_q, w_data_q, w_strb_q, TCTL_WMASK) : t2_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      ext_q    <= EXT_RST;
      gpt_q    <= GPT_RST;
      com_q    <= COM_RST;
      flag_q   <= 1'b0;
      mask_a_q <= MASK_A_RST;
      ba_q     <= MASK_BA_RST;
      bb_q     <= MASK_BB_RST;
      bc_q     <= MASK_BC_RST;
      t1_q     <= TCTL_RST;
      t2_q     <= TCTL_RST;
    end else if (ce) begin
      ext_q    <= ext_d;
      gpt_q    <= gpt_d;
      com_q    <= com_d;
      flag_q   <= flag_d;
      mask_a_q <= mask_a_d;
      ba_q     <= ba_d;
      bb_q     <= bb_d;
      bc_q     <= bc_d;
      t1_q     <= t1_d;
      t2_q     <= t2_d;
    end
  end

  wire [REG_W-1:0] flag_word = REG_W'(flag_q) << FLAG_PROT;
  assign rd_word =
      (rd_sel == REG_EXT)     ? ext_q    :
      (rd_sel == REG_GPT)     ? gpt_q    :
      (rd_sel == REG_COM)     ? com_q    :
      (rd_sel == REG_FLAG)    ? flag_word :
      (rd_sel == REG_MASK_A)  ? mask_a_q :
      (rd_sel == REG_MASK_BA) ? ba_q     :
      (rd_sel == REG_MASK_BB) ? bb_q     :
      (rd_sel == REG_MASK_BC) ? bc_q     :
      (rd_sel == REG_T1CTL)   ? t1_q     :
      (rd_sel == REG_T2CTL)   ? t2_q     : '0;

  // ---------------- output buffer control
  cmp_pins_s oe_n_d, pin_o_q, oe_n_q;
  logic [1:0] tmr_en;
  assign tmr_en = indep ? (gpt_q[GPT_T1OE +: 2] & ~{t2_hit, t1_hit})
                        : {2{gpt_q[GPT_TOE] && !prot_active}};
  assign oe_n_d.tmr = ~tmr_en;
  for (genvar i = 0; i < 3; i++) begin : g_fc_oe
    wire en = indep ? (com_q[COM_FOE_LO+i] && !fc_hit[i])
                    : (com_q[COM_FOE] && !prot_active);
    assign oe_n_d.fc[2*i +: 2] = {2{!en}};
  end

  logic       irq_q, clr_q, idx_prev_q;
  logic [2:0] t1_sel_q, t2_sel_q;
  wire        qual_ok   = !ext_q[EXT_QUAL] || (pins.qa && pins.qb);
  wire        idx_clear = ext_q[EXT_INDEX] && pins.idx && !idx_prev_q && qual_ok;

  always_ff @(posedge clock) begin
    if (rst) begin
      pin_o_q    <= '0;
      oe_n_q     <= '1;
      irq_q      <= 1'b0;
      clr_q      <= 1'b0;
      idx_prev_q <= 1'b0;
      t1_sel_q   <= 3'h1;
      t2_sel_q   <= 3'h1;
    end else if (ce) begin
      pin_o_q    <= cmp_drive;
      oe_n_q     <= oe_n_d;
      irq_q      <= flag_q && mask_a_q[MASK_PROT];
      clr_q      <= idx_clear;
      idx_prev_q <= pins.idx;
      t1_sel_q   <= clk_src_onehot(t1_q[CLK_SEL_LO +: 2]);
      t2_sel_q   <= clk_src_onehot(t2_q[CLK_SEL_LO +: 2]);
    end
  end

  assign cmp_pin_o        = pin_o_q;
  assign cmp_pin_oe_n     = oe_n_q;
  assign protection_irq   = irq_q;
  assign quad_timer_clear = clr_q;
  assign timer1_clk_sel   = t1_sel_q;
  assign timer2_clk_sel   = t2_sel_q;
  assign b_group_a_irq_en = ba_q;
  assign b_timer4_irq_en  = bb_q[3:0];
  assign b_capture_irq_en = bc_q[2:0];
  assign internal_conv_trigger = conv_event;

  conv_start_pulse #(
    .LEN (SOC_LEN)
  ) u_soc (
    .clock    (clock),
    .rst      (rst),
    .ce       (ce),
    .fire     (conv_event),
    .enable   (ext_q[EXT_SOC]),
    .pin_o    (conv_start_pin_o),
    .pin_oe_n (conv_start_pin_oe_n)
  );

  // ---------------- checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  soc_hiz_a: assert property (!ext_q[EXT_SOC] |-> conv_start_pin_oe_n)
    else $error("conversion pin driven while disabled");
  index_off_a: assert property (ce && !ext_q[EXT_INDEX] |=> !quad_timer_clear)
    else $error("index clear while index disabled");
  grouped_oe_a: assert property (ce && !indep && !prot_active
      |=> cmp_pin_oe_n.tmr == {2{!$past(gpt_q[GPT_TOE])}})
    else $error("grouped timer enable not followed");
  t2_trip_a: assert property (ce && indep && gpt_q[GPT_T2TRIPE] && !pins.t2_trip
      |=> !gpt_q[GPT_T1OE+1] && flag_q && cmp_pin_oe_n.tmr[1])
    else $error("timer 2 trip not handled");
  t1_trip_hiz_a: assert property (ce && indep && gpt_q[GPT_T1TRIPE] && !pins.t1_trip
      |=> cmp_pin_oe_n.tmr[0] && !gpt_q[GPT_T1OE])
    else $error("timer 1 trip not handled");
  trip_ignored_a: assert property (ce && indep && !gpt_q[GPT_T1TRIPE]
      && gpt_q[GPT_T1OE] && !wr_gpt |=> gpt_q[GPT_T1OE])
    else $error("disabled trip cleared an enable");
  compat_clear_a: assert property (ce && prot_active
      |=> !gpt_q[GPT_TOE] && !com_q[COM_FOE] && cmp_pin_oe_n == '1)
    else $error("protection did not tri-state outputs");
  fc_trip_a: assert property (ce && fc_hit[0]
      |=> cmp_pin_oe_n.fc[1:0] == 2'h3 && !com_q[COM_FOE_LO] && flag_q)
    else $error("full compare trip not handled");
  mask_only_a: assert property (ce && indep && gpt_q[GPT_T1OE] && !t1_hit
      && mask_a_q[MASK_PROT] |=> !cmp_pin_oe_n.tmr[0])
    else $error("mask gated output in independent mode");

endmodule : trip_hiz_ext_ctrl

// ---- tb/power_stage_model.sv ----
`timescale 1ns/1ps
module power_stage_model
  import ext_ctrl_pkg::*;
(
  input  wire logic  clock,
  input  wire logic  t1_low,
  input  wire logic  t2_low,
  input  wire logic  fc_low,
  input  wire logic  quad_low,
  input  wire logic  idx_hi,
  output sense_pins_s sense,
  output cmp_pins_s   drive
);
  logic [7:0] pat_q = 8'h5a;
  // trips idle high on pull-ups; the bench holds a low far past the qualifier
  assign sense = '{idx: idx_hi, qb: 1'b1, qa: ~quad_low, fc_trip: {2'b11, ~fc_low},
                   t2_trip: ~t2_low, t1_trip: ~t1_low};
  // waveform moves every cycle so a stuck pin copy cannot hide
  always @(posedge clock) pat_q <= {pat_q[6:0], ~pat_q[7]};
  assign drive = pat_q;
endmodule : power_stage_model

// ---- tb/trip_hiz_ext_ctrl_tb.sv ----
`timescale 1ns/1ps
module trip_hiz_ext_ctrl_tb;
  import ext_ctrl_pkg::*;
  logic              clock = 1'b0, rst = 1'b1, conv_event = 1'b0;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0, got;
  logic [3:0]        wstrb = 4'h0, t4en;
  logic [2:0]        clk1, clk2, cap_en;
  logic [1:0]        rsp, bresp, rresp;
  logic              t1_low = 1'b0, t2_low = 1'b0, idx_hi = 1'b0, ce = 1'b1;
  logic              fc_low = 1'b0, quad_low = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid, ict, soc_o, soc_oe_n, qclr, pirq;
  logic [DATA_W-1:0] rdata;
  sense_pins_s       sense;
  cmp_pins_s         drive, pin_oe_n, pin_o, drive_q;
  int                err_total = 0, n_tests = 0, seed = 35, n, mdl[int];
  int                cds[4] = '{0, 4, 6, 6};
  int                eq[4] = '{0, 1, 1, 0};
  logic [15:0]       v, ga_en;

  always #4 clock = ~clock;
  always @(posedge clock) drive_q <= drive;

  power_stage_model i_ps (.clock(clock), .t1_low(t1_low), .t2_low(t2_low), .fc_low(fc_low),
                          .quad_low(quad_low), .idx_hi(idx_hi), .sense(sense), .drive(drive));
  trip_hiz_ext_ctrl #(.QUAL_LEN(2)) i_dut (.clock(clock), .rst(rst), .ce(ce),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .sense_raw(sense),
    .cmp_drive(drive), .cmp_pin_o(pin_o), .cmp_pin_oe_n(pin_oe_n), .conv_event(conv_event),
    .internal_conv_trigger(ict), .conv_start_pin_o(soc_o), .conv_start_pin_oe_n(soc_oe_n),
    .quad_timer_clear(qclr), .timer1_clk_sel(clk1), .timer2_clk_sel(clk2),
    .protection_irq(pirq), .b_group_a_irq_en(ga_en), .b_timer4_irq_en(t4en),
    .b_capture_irq_en(cap_en));

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  // write handshake; readies sampled mid-cycle, released after the taking edge
  task wr(input int ix, input logic [15:0] d, input logic [15:0] m);
    logic a_t, w_t, b_t;
    int k;
    k = 0;
    @(posedge clock);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= {ix[15:0], 2'b00};
    wdata <= {16'h0000, d};
    wstrb <= 4'h3;
    bready <= 1'b1;
    do begin
      @(negedge clock);
      a_t = awvalid & awready;
      w_t = wvalid & wready;
      b_t = bvalid;
      rsp = bresp;
      @(posedge clock);
      if (a_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      k++;
    end while (!b_t && k < 50);
    bready <= 1'b0;
    chk("write answer", b_t, 1'b1);
    if (mdl.exists(ix)) mdl[ix] = (mdl[ix] & ~m) | (d & m);
    chk("bresp", rsp, mdl.exists(ix) ? RESP_OKAY : RESP_SLVERR);
  endtask : wr

  task rd(input int ix, input string nm);
    logic a_t, r_t;
    int k;
    k = 0;
    @(posedge clock);
    arvalid <= 1'b1;
    araddr <= {ix[15:0], 2'b00};
    rready <= 1'b1;
    do begin
      @(negedge clock);
      a_t = arvalid & arready;
      r_t = rvalid;
      got = rdata;
      rsp = rresp;
      @(posedge clock);
      if (a_t) arvalid <= 1'b0;
      k++;
    end while (!r_t && k < 50);
    rready <= 1'b0;
    chk("read answer", r_t, 1'b1);
    if (mdl.exists(ix)) chk(nm, got, mdl[ix]);
    chk("rresp", rsp, mdl.exists(ix) ? RESP_OKAY : RESP_SLVERR);
  endtask : rd

  // trips held 20 cycles, well past the shortened qualifier
  task trip(input int t2);
    @(posedge clock);
    if (t2 == 2) fc_low <= 1'b1;
    else if (t2 != 0) t2_low <= 1'b1;
    else t1_low <= 1'b1;
    repeat (20) @(posedge clock);
    t1_low <= 1'b0;
    t2_low <= 1'b0;
    fc_low <= 1'b0;
    repeat (20) @(posedge clock);
  endtask : trip

  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    give_verdict();
  end

  initial begin
    mdl[IDX_EXT] = EXT_RST;
    mdl[IDX_GPT] = GPT_RST;
    mdl[IDX_COM] = COM_RST;
    mdl[IDX_FLAG] = 0;
    mdl[IDX_MASK_A] = MASK_A_RST;
    mdl[IDX_MASK_BB] = MASK_BB_RST;
    mdl[IDX_MASK_BC] = MASK_BC_RST;
    mdl[IDX_T1CTL] = TCTL_RST;
    mdl[IDX_T2CTL] = TCTL_RST;
    mdl[IDX_MASK_BA] = MASK_BA_RST;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    foreach (mdl[i]) rd(i, "reset value");
    rd(16'h7000, "unmapped");
    $display("test reset values done");
    repeat (4) begin
      v = 16'($random(seed));
      wr(IDX_MASK_BA, v, MASK_BA_WMASK);
      wr(IDX_MASK_BB, v, MASK_BB_WMASK);
      wr(IDX_MASK_BC, v, MASK_BC_WMASK);
      rd(IDX_MASK_BB, "timer4 mask");
      rd(IDX_MASK_BC, "capture mask");
      chk("timer4 enables", t4en, mdl[IDX_MASK_BB]);
      chk("capture enables", cap_en, mdl[IDX_MASK_BC]);
      chk("group a enables", ga_en, mdl[IDX_MASK_BA]);
    end
    $display("test masks done");
    for (int c = 0; c < 4; c++) begin
      n = c ^ 1;
      wr(IDX_T1CTL, 16'(c << 4), TCTL_WMASK);
      wr(IDX_T2CTL, 16'(n << 4), TCTL_WMASK);
      repeat (2) @(posedge clock);
      chk("clock select", clk1, (c == 2) ? 0 : (c == 3) ? 4 : (1 << c));
      chk("clock select 2", clk2, (n == 2) ? 0 : (n == 3) ? 4 : (1 << n));
    end
    $display("test clock select done");
    for (int e = 1; e >= 0; e--) begin
      wr(IDX_EXT, 16'(e * 8), EXT_WMASK);
      @(posedge clock);
      conv_event <= 1'b1;
      @(negedge clock);
      chk("internal trigger", ict, 1);
      @(posedge clock);
      conv_event <= 1'b0;
      n = 0;
      repeat (40) begin
        @(negedge clock);
        if (soc_o === 1'b0) n++;
      end
      chk("conversion pin hiz", soc_oe_n, 1 - e);
      chk("pulse length", n, e * SOC_PULSE_CYCLES);
    end
    $display("test conversion start done");
    for (int j = 0; j < 4; j++) begin
      wr(IDX_EXT, 16'(cds[j]), EXT_WMASK);
      quad_low <= (j == 3);
      repeat (8) @(posedge clock);
      idx_hi <= 1'b1;
      n = 0;
      repeat (20) begin
        @(negedge clock);
        if (qclr === 1'b1) n++;
      end
      @(posedge clock);
      idx_hi <= 1'b0;
      repeat (20) @(posedge clock);
      chk("index clears", n, eq[j]);
    end
    $display("test index done");
    wr(IDX_EXT, 16'h0001, EXT_WMASK);
    wr(IDX_GPT, 16'h0030, GPT_WMASK);
    trip(1);
    rd(IDX_GPT, "gpt trip off");
    rd(IDX_FLAG, "flag trip off");
    chk("timer hiz", pin_oe_n.tmr, 2'b00);
    wr(IDX_GPT, 16'h1830, GPT_WMASK);
    trip(0);
    mdl[IDX_GPT] = 16'h1820;
    mdl[IDX_FLAG] = 1;
    rd(IDX_GPT, "gpt t1 trip");
    rd(IDX_FLAG, "flag t1 trip");
    chk("timer1 hiz", pin_oe_n.tmr, 2'b01);
    chk("protection irq", pirq, 1);
    trip(1);
    mdl[IDX_GPT] = 16'h1800;
    rd(IDX_GPT, "gpt t2 trip");
    chk("timer2 hiz", pin_oe_n.tmr, 2'b11);
    wr(IDX_GPT, 16'h1830, GPT_WMASK);
    repeat (2) @(posedge clock);
    chk("timer restored", pin_oe_n.tmr, 2'b00);
    ce <= 1'b0;
    trip(0);
    ce <= 1'b1;
    rd(IDX_GPT, "gpt frozen");
    wr(IDX_FLAG, 16'h0001, 16'h0000);
    mdl[IDX_FLAG] = 0;
    rd(IDX_FLAG, "flag cleared");
    wr(IDX_COM, 16'h0021, COM_WMASK);
    repeat (2) @(posedge clock);
    chk("fc driven", pin_oe_n.fc, 6'h3c);
    trip(2);
    mdl[IDX_COM] = 16'h0001;
    mdl[IDX_FLAG] = 1;
    rd(IDX_COM, "com fc trip");
    rd(IDX_FLAG, "flag fc trip");
    chk("fc hiz", pin_oe_n.fc, 6'h3f);
    $display("test independent trips done");
    wr(IDX_EXT, 16'h0000, EXT_WMASK);
    wr(IDX_GPT, 16'h0040, GPT_WMASK);
    wr(IDX_COM, 16'h0200, COM_WMASK);
    wr(IDX_FLAG, 16'h0001, 16'h0000);
    mdl[IDX_FLAG] = 0;
    repeat (2) @(posedge clock);
    chk("all driven", pin_oe_n, 8'h00);
    @(negedge clock);
    chk("pin copy", pin_o, drive_q);
    trip(0);
    mdl[IDX_GPT] = 16'h0000;
    mdl[IDX_COM] = 16'h0000;
    mdl[IDX_FLAG] = 1;
    rd(IDX_GPT, "grouped timer");
    rd(IDX_COM, "grouped fullcmp");
    rd(IDX_FLAG, "flag compat");
    chk("all hiz", pin_oe_n, 8'hff);
    wr(IDX_MASK_A, 16'h0000, MASK_A_WMASK);
    wr(IDX_GPT, 16'h0040, GPT_WMASK);
    wr(IDX_COM, 16'h0200, COM_WMASK);
    trip(0);
    rd(IDX_GPT, "gpt mask off");
    chk("mask off driven", pin_oe_n, 8'h00);
    chk("mask off irq", pirq, 1'b0);
    $display("test compatibility trip done");
    give_verdict();
  end
endmodule : trip_hiz_ext_ctrl_tb
